// ==== ssmd_pkg.sv ====
// Constants for the startup switch and mode decoder.
// Assumes a single 10 MHz core clock and static installer switches.
package ssmd_pkg;
  // ----------------------------------------------------------------
  // Clock and settle timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int SETTLE_US       = 100;
  localparam int SETTLE_CYCLES   = (SETTLE_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                   SETTLE_US * (CLK_HZ / 1_000_000);
  // ----------------------------------------------------------------
  // Fixed network address and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] FIXED_ADDR      = 32'hC0A8_0001;
  localparam int          LIN_FIXED_BIT   = 0;
  localparam int          LIN_RECOVER_BIT = 1;
  // ----------------------------------------------------------------
  // Rotary code boundaries
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_FIRST_BUS  = 8'h00;
  localparam logic [7:0] CODE_NODE_LAST  = 8'hEF;
  localparam logic [7:0] CODE_THIRD_BUS  = 8'hF2;
  // ----------------------------------------------------------------
  // Encoder numbering
  // ----------------------------------------------------------------
  localparam logic [1:0] ENC_MOTOR_FEEDBACK = 2'h0;
  localparam logic [1:0] ENC_FAST_INPUTS    = 2'h1;
  localparam logic [1:0] ENC_AUXILIARY      = 2'h2;
  // ----------------------------------------------------------------
  // Reset values and types
  // ----------------------------------------------------------------
  localparam logic [1:0] LIN_RESET = 2'h0;
  localparam logic [7:0] ROT_RESET = 8'h00;
  typedef enum logic [1:0] {
    SSMD_MODE_NONE  = 2'b00,
    SSMD_MODE_FIRST = 2'b01,
    SSMD_MODE_NODE  = 2'b10,
    SSMD_MODE_THIRD = 2'b11
  } ssmd_mode_type;
  typedef enum logic [1:0] {
    SSMD_ST_SETTLE = 2'b00,
    SSMD_ST_SAMPLE = 2'b01,
    SSMD_ST_HOLD   = 2'b10
  } ssmd_state_type;
endpackage

// ==== ssmd_sync.sv ====
// Two-flop synchroniser for a bus of static switch levels.
// Assumes the inputs are quasi-static; bits may land one cycle apart.
`timescale 1ns/1ps
module ssmd_sync #(
  parameter int WIDTH = 10
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;
  // First stage feeds only the second stage
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule

// ==== ssmd_decoder.sv ====
// Startup switch sampler and fieldbus mode decoder.
// Assumes switch pins are asynchronous and static after power-up.
`timescale 1ns/1ps
module ssmd_decoder
  import ssmd_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic [1:0] startup_linear_switch_pair_in,
  input  wire logic [3:0] rotary_high_digit_in,
  input  wire logic [3:0] rotary_low_digit_in,
  output logic            config_valid_out,
  output logic            fixed_addr_sel_out,
  output logic [31:0]     network_addr_override_out,
  output logic            recovery_mode_out,
  output logic            download_enable_out,
  output logic            recovery_symbol_out,
  output logic [7:0]      mode_code_out,
  output logic [1:0]      realtime_mode_out,
  output logic            controlled_node_role_out,
  output logic [7:0]      node_id_out,
  output logic            third_bus_on_realtime_port_out,
  output logic            third_bus_on_host_network_port_out,
  output logic            invalid_config_out,
  output logic [1:0]      motor_feedback_connector_enc_out,
  output logic [1:0]      fast_input_pair_enc_out,
  output logic [1:0]      auxiliary_encoder_connector_enc_out
);
  // ----------------------------------------------------------------
  // Switch synchronisation
  // ----------------------------------------------------------------
  logic [9:0]     sw_sync;
  logic [15:0]    settle_cnt;
  ssmd_state_type state;
  logic [1:0]     lin_held;
  logic [7:0]     rot_held;
  logic           sample_now;

  ssmd_sync #(.WIDTH(10)) u_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .async_in    ({startup_linear_switch_pair_in, rotary_high_digit_in, rotary_low_digit_in}),
    .sync_out    (sw_sync)
  );

  // Decode a held code to the realtime port mode
  function automatic ssmd_mode_type mode_of(input logic [7:0] code);
    if (code == CODE_FIRST_BUS) begin
      mode_of = SSMD_MODE_FIRST;
    end else if (code <= CODE_NODE_LAST) begin
      mode_of = SSMD_MODE_NODE;
    end else if (code == CODE_THIRD_BUS) begin
      mode_of = SSMD_MODE_THIRD;
    end else begin
      mode_of = SSMD_MODE_NONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // Startup sequencer
  // ----------------------------------------------------------------
  // Waits for switch contacts to settle so a bounce is not latched
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state      <= SSMD_ST_SETTLE;
      settle_cnt <= '0;
    end else begin
      case (state)
        SSMD_ST_SETTLE: begin
          if (settle_cnt >= 16'(SETTLE - 1)) begin
            state <= SSMD_ST_SAMPLE;
          end else begin
            settle_cnt <= settle_cnt + 16'h0001;
          end
        end
        SSMD_ST_SAMPLE: begin
          state <= SSMD_ST_HOLD;
        end
        SSMD_ST_HOLD: begin
          state <= SSMD_ST_HOLD;
        end
        default: begin
          state <= SSMD_ST_SETTLE;
        end
      endcase
    end
  end

  assign sample_now = (state == SSMD_ST_SAMPLE);

  // ----------------------------------------------------------------
  // One-shot capture
  // ----------------------------------------------------------------
  // linear capture once
  // rotary capture once; only reset restarts, later movement ignored
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lin_held <= LIN_RESET;
      rot_held <= ROT_RESET;
    end else if (sample_now) begin
      lin_held <= sw_sync[9:8];
      rot_held <= sw_sync[7:0];   // High digit in upper nibble
    end
  end

  // ----------------------------------------------------------------
  // Decoded outputs, all registered
  // ----------------------------------------------------------------
  // Outputs stay at safe values until the capture is complete
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      config_valid_out                   <= 1'b0;
      fixed_addr_sel_out                 <= 1'b0;
      network_addr_override_out          <= 32'h0000_0000;
      recovery_mode_out                  <= 1'b0;
      download_enable_out                <= 1'b0;
      recovery_symbol_out                <= 1'b0;
      mode_code_out                      <= 8'h00;
      realtime_mode_out                  <= SSMD_MODE_NONE;
      controlled_node_role_out           <= 1'b0;
      node_id_out                        <= 8'h00;
      third_bus_on_realtime_port_out     <= 1'b0;
      third_bus_on_host_network_port_out <= 1'b0;
      invalid_config_out                 <= 1'b0;
      motor_feedback_connector_enc_out   <= ENC_MOTOR_FEEDBACK;
      fast_input_pair_enc_out            <= ENC_FAST_INPUTS;
      auxiliary_encoder_connector_enc_out <= ENC_AUXILIARY;
    end else if (state == SSMD_ST_HOLD) begin
      config_valid_out <= 1'b1;
      // recovery also forces the fixed address
      fixed_addr_sel_out <= lin_held[LIN_FIXED_BIT] | lin_held[LIN_RECOVER_BIT];
      network_addr_override_out <=
        (lin_held[LIN_FIXED_BIT] | lin_held[LIN_RECOVER_BIT]) ? FIXED_ADDR : 32'h0000_0000;
      recovery_mode_out   <= lin_held[LIN_RECOVER_BIT];
      download_enable_out <= lin_held[LIN_RECOVER_BIT];
      recovery_symbol_out <= lin_held[LIN_RECOVER_BIT];
      mode_code_out <= rot_held;
      realtime_mode_out <= mode_of(rot_held);
      controlled_node_role_out <= (mode_of(rot_held) == SSMD_MODE_NODE);
      node_id_out <= (mode_of(rot_held) == SSMD_MODE_NODE) ? rot_held : 8'h00;
      third_bus_on_realtime_port_out <= (rot_held == CODE_THIRD_BUS);
      third_bus_on_host_network_port_out <= (rot_held <= CODE_NODE_LAST);
      invalid_config_out <= (mode_of(rot_held) == SSMD_MODE_NONE);
      motor_feedback_connector_enc_out    <= ENC_MOTOR_FEEDBACK;
      fast_input_pair_enc_out             <= ENC_FAST_INPUTS;
      auxiliary_encoder_connector_enc_out <= ENC_AUXILIARY;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  a_hold_linear: assert property (config_valid_out && $past(config_valid_out) |->
    $stable(recovery_mode_out) && $stable(fixed_addr_sel_out))
    else $error("linear settings changed after startup");
  a_fixed_addr: assert property (config_valid_out && fixed_addr_sel_out |->
    network_addr_override_out == 32'hC0A8_0001)
    else $error("fixed address wrong");
  a_recovery_set: assert property (recovery_mode_out |->
    fixed_addr_sel_out && download_enable_out && recovery_symbol_out)
    else $error("recovery effects incomplete");
  a_hold_code: assert property (config_valid_out && $past(config_valid_out) |->
    $stable(mode_code_out))
    else $error("mode code changed after startup");
  a_first_bus: assert property (config_valid_out |->
    ((mode_code_out == 8'h00) == (realtime_mode_out == SSMD_MODE_FIRST)))
    else $error("code 00 decode wrong");
  a_node_id: assert property (controlled_node_role_out |->
    node_id_out == mode_code_out && mode_code_out >= 8'h01 && mode_code_out <= 8'hEF)
    else $error("node id wrong");
  a_third_bus: assert property (config_valid_out |->
    (third_bus_on_realtime_port_out == (mode_code_out == 8'hF2)))
    else $error("F2 decode wrong");
  a_host_route: assert property (config_valid_out |->
    (third_bus_on_host_network_port_out == (mode_code_out <= 8'hEF)))
    else $error("host port routing wrong");
  a_enc_number: assert property (motor_feedback_connector_enc_out == 2'h0 &&
    fast_input_pair_enc_out == 2'h1 && auxiliary_encoder_connector_enc_out == 2'h2)
    else $error("encoder numbering wrong");
  a_reserved: assert property (invalid_config_out |->
    realtime_mode_out == SSMD_MODE_NONE && !third_bus_on_host_network_port_out)
    else $error("reserved code not flagged");
  a_valid_time: assert property ($rose(config_valid_out) |-> $past(sample_now, 2))
    else $error("valid not after sample");

  c_recovery: cover property ($rose(recovery_mode_out));
  c_node:     cover property ($rose(controlled_node_role_out));
  c_third:    cover property ($rose(third_bus_on_realtime_port_out));
  c_invalid:  cover property ($rose(invalid_config_out));
endmodule

// ==== ssmd_switch_model.sv ====
// Installer switch model for the startup decoder bench.
// Assumes the bench sets startup positions while the decoder is held in reset; later moves come after capture.
`timescale 1ns/1ps
module ssmd_switch_model (
  input  wire logic [1:0] set_lin_in,
  input  wire logic [3:0] set_high_in,
  input  wire logic [3:0] set_low_in,
  output logic      [1:0] lin_out,
  output logic      [3:0] high_out,
  output logic      [3:0] low_out
);
  // ----------------------------------------------------------------
  // Contacts
  // ----------------------------------------------------------------
  // Plain levels; bounce is not modelled, so settle timing is not stressed
  assign lin_out = set_lin_in;
  assign high_out = set_high_in;
  assign low_out  = set_low_in;
endmodule

// ==== startup_switch_mode_decoder_tb.sv ====
// Self-checking bench for the startup switch and mode decoder.
// Assumes a shortened settle count; every case restarts the block.
`timescale 1ns/1ps
module startup_switch_mode_decoder_tb;
  import ssmd_pkg::*;
  localparam int SETTLE_SIM = 4;
  logic        core_clk_in;
  logic        rst_in;
  logic [1:0]  set_lin;
  logic [3:0]  set_high, set_low, high_w, low_w;
  logic [1:0]  lin_w, rt_mode, enc_m, enc_f, enc_a;
  logic        cfg_v, fix_sel, rec, dl, sym, node_o, th_rt, th_host, inv;
  logic [31:0] addr;
  logic [7:0]  code_o, nid;
  logic [7:0]  codes [9] = '{8'h00, 8'h01, 8'h7F, 8'hEF, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hFF};
  int          fails, n_compared;

  ssmd_switch_model sw_u (.set_lin_in(set_lin), .set_high_in(set_high), .set_low_in(set_low),
                          .lin_out(lin_w), .high_out(high_w), .low_out(low_w));
  ssmd_decoder #(.SETTLE(SETTLE_SIM)) dut_u (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .startup_linear_switch_pair_in(lin_w),
    .rotary_high_digit_in(high_w), .rotary_low_digit_in(low_w), .config_valid_out(cfg_v),
    .fixed_addr_sel_out(fix_sel), .network_addr_override_out(addr),
    .recovery_mode_out(rec), .download_enable_out(dl), .recovery_symbol_out(sym),
    .mode_code_out(code_o), .realtime_mode_out(rt_mode), .controlled_node_role_out(node_o),
    .node_id_out(nid), .third_bus_on_realtime_port_out(th_rt),
    .third_bus_on_host_network_port_out(th_host), .invalid_config_out(inv),
    .motor_feedback_connector_enc_out(enc_m), .fast_input_pair_enc_out(enc_f),
    .auxiliary_encoder_connector_enc_out(enc_a));

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end
  // Nine restarts of about 25 cycles each fit well inside this span
  initial begin
    #200_000;
    fails++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Compare and verdict
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Startup with given switch positions
  // ----------------------------------------------------------------
  task automatic start_up(input logic [1:0] lin, input logic [7:0] c);
    int cnt;
    @(posedge core_clk_in);
    #1;
    rst_in = 1'b1;
    set_lin = lin;
    set_high = c[7:4];
    set_low = c[3:0];
    repeat (12) @(posedge core_clk_in);
    #1;
    chk(cfg_v, 0, "valid in reset");
    chk(rt_mode, SSMD_MODE_NONE, "mode in reset");
    rst_in = 1'b0;
    cnt = 0;
    // Bounded wait; the latency itself is a checked figure
    while (cfg_v !== 1'b1 && cnt < SETTLE_SIM + 20) begin
      @(posedge core_clk_in);
      #1;
      cnt++;
    end
    chk(32'(cnt), SETTLE_SIM + 2, "capture latency");
  endtask

  // Expected settings worked out from the switch positions alone
  task automatic check_all(input logic [1:0] lin, input logic [7:0] c);
    logic fx, is_node;
    fx = lin[0] | lin[1];
    is_node = (c != 8'h00) && (c <= 8'hEF);
    chk(cfg_v, 1, "valid");
    chk(fix_sel, fx, "fixed select");
    chk(addr, fx ? FIXED_ADDR : 32'h0000_0000, "address");
    chk({rec, dl, sym}, {3{lin[1]}}, "recovery");
    chk(code_o, c, "code");
    chk(rt_mode, (c == 8'h00) ? SSMD_MODE_FIRST : is_node ? SSMD_MODE_NODE :
        (c == 8'hF2) ? SSMD_MODE_THIRD : SSMD_MODE_NONE, "mode");
    chk({node_o, nid}, {is_node, is_node ? c : 8'h00}, "node");
    chk(th_rt, c == 8'hF2, "third on realtime");
    chk(th_host, c <= 8'hEF, "third on host");
    chk(inv, (c > 8'hEF) && (c != 8'hF2), "invalid");
    chk({enc_m, enc_f, enc_a}, {ENC_MOTOR_FEEDBACK, ENC_FAST_INPUTS, ENC_AUXILIARY}, "enc");
  endtask

  // ----------------------------------------------------------------
  // Tests: every code class and linear setting, then moved switches
  // ----------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    set_lin = 2'h0;
    set_high = 4'h0;
    set_low = 4'h0;
    fails = 0;
    n_compared = 0;
    for (int i = 0; i < 9; i++) begin
      start_up(2'(i), codes[i]);
      check_all(2'(i), codes[i]);
      @(posedge core_clk_in);
      #1;
      set_lin = ~2'(i);
      set_high = ~codes[i][7:4];
      set_low = ~codes[i][3:0];
      repeat (6) @(posedge core_clk_in);
      #1;
      check_all(2'(i), codes[i]);
    end
    stop_test();
  end
endmodule
